// file: core/charge_control_sequencer.sv
`timescale 1ns/1ps
module charge_control_sequencer #(
	parameter int TICK_CYCLES = charge_pkg::TICK_CYCLES_DEF, // Clocks per timer tick
	parameter int PRE_TICKS = charge_pkg::PRE_TICKS_DEF, // Pre-charge limit in ticks
	parameter int FAST_TICKS = charge_pkg::FAST_TICKS_DEF, // Fast-charge limit in ticks
	parameter int BOOST_TICKS = charge_pkg::BOOST_TICKS_DEF // Boost window in ticks
) (
	input wire logic CLK, // System clock, 100 MHz
	input wire logic SRST, // Synchronous reset, active high
	input wire logic [7:0] S_AXI_AWADDR, // Write address
	input wire logic S_AXI_AWVALID, // Write address valid
	output logic S_AXI_AWREADY, // Write address ready
	input wire logic [31:0] S_AXI_WDATA, // Write data
	input wire logic [3:0] S_AXI_WSTRB, // Write byte strobes
	input wire logic S_AXI_WVALID, // Write data valid
	output logic S_AXI_WREADY, // Write data ready
	output logic [1:0] S_AXI_BRESP, // Write response
	output logic S_AXI_BVALID, // Write response valid
	input wire logic S_AXI_BREADY, // Write response ready
	input wire logic [7:0] S_AXI_ARADDR, // Read address
	input wire logic S_AXI_ARVALID, // Read address valid
	output logic S_AXI_ARREADY, // Read address ready
	output logic [31:0] S_AXI_RDATA, // Read data
	output logic [1:0] S_AXI_RRESP, // Read response
	output logic S_AXI_RVALID, // Read data valid
	input wire logic S_AXI_RREADY, // Read data ready
	input wire logic ISEL_LOW, // Current select pin driven low
	input wire logic ISEL_HIGH, // Current select pin driven high
	input wire logic SENSE_LOW, // Thermistor sense pulled low
	input wire logic SENSE_MODE, // Thermistor sense above mode threshold
	input wire logic TEMP_COLD, // Battery below 0 C
	input wire logic TEMP_COOL, // Battery 0 C to 10 C
	input wire logic TEMP_WARM, // Battery 45 C to 60 C
	input wire logic TEMP_HOT, // Battery above 60 C
	input wire logic BATT_ENABLE_OFF, // Battery enable control in its disable level
	input wire logic POWER_GOOD, // Input supply valid
	input wire logic BAT_LOWV, // Battery below pre-charge threshold
	input wire logic ABOVE_RCH, // Output above recharge threshold
	input wire logic TAPER_TERM, // Current at termination threshold
	input wire logic THERMAL_REG, // Die in thermal regulation
	input wire logic FOLDBACK, // Input voltage foldback active
	input wire logic USB_LIMIT, // Input current limit active
	input wire logic DET_DONE, // Detect probe finished, one cycle
	input wire logic DET_PRESENT, // Probe result, valid with DET_DONE
	output logic DET_RUN, // Detect probe request
	output logic CHARGE_EN, // Power stage enable
	output logic [1:0] CUR_LIMIT_SEL, // Input current limit code
	output logic HALF_CURRENT, // Halve the charge current
	output logic VREG_REDUCED, // Use the reduced voltage setpoint
	output logic TERM_BOOST, // Raise termination threshold
	output logic STATUS_O, // Status pin drive value, always low
	output logic STATUS_OE_N // Status pin enable, low while pulling
);
	import charge_pkg::*;

	// Refuse counts the prescaler and timers cannot serve
	if (TICK_CYCLES < 2 || PRE_TICKS < 1 || FAST_TICKS < 1 || BOOST_TICKS < 1) begin : g_bad_counts
		$error("charge_control_sequencer: counts out of range");
	end

	charge_state_t state_ff, nxt_state; // Sequencer state
	det_why_t why_ff, nxt_why; // Reason for current detect
	logic [31:0] ctrl_ff; // Control register
	logic [31:0] pre_ff; // Clock prescaler
	logic slow_ff; // Alternate-tick gate for slowed modes
	logic tick; // Timer tick strobe
	logic [31:0] tmr_ff; // Safety timer in ticks
	logic [31:0] boost_ff; // Ticks since cycle start
	logic mode_ff; // Mode flag, delayed for edge detection
	logic first_ff; // Status shows first charge
	logic absent_ff; // Last detect found no battery
	logic disabled, fault, slowed, start_cycle, det_go;

	// Charge is blocked by the sense pin, enable pin, software or supply
	assign disabled = SENSE_LOW | BATT_ENABLE_OFF | ctrl_ff[CTRL_DISABLE_BIT] | !POWER_GOOD;
	// Temperature fault, ignored when the pin is out of the thermistor range
	assign fault = (TEMP_COLD | TEMP_HOT) & !SENSE_MODE & !SENSE_LOW;
	assign slowed = THERMAL_REG | FOLDBACK | USB_LIMIT;
	// Detect stalls in the mode (except its own entry check) and in faults
	assign det_go = !fault & (!SENSE_MODE | why_ff == WHY_MODE_IN);

	// Prescaler: one strobe per TICK_CYCLES, every second strobe when slowed
	always_ff @(posedge CLK) begin
		if (SRST || disabled) begin
			pre_ff <= '0;
			slow_ff <= 1'b0;
		end else if (pre_ff == 32'(TICK_CYCLES - 1)) begin
			pre_ff <= '0;
			slow_ff <= !slow_ff;
		end else begin
			pre_ff <= pre_ff + 32'h0000_0001;
		end
	end
	assign tick = (pre_ff == 32'(TICK_CYCLES - 1)) & (!slowed | slow_ff);

	// Mode edge tracking
	always_ff @(posedge CLK) begin
		if (SRST)
			mode_ff <= 1'b0;
		else
			mode_ff <= SENSE_MODE;
	end

	// A new cycle starts in pre-charge or fast charge by battery level
	function automatic charge_state_t cycle_entry(input logic lowv);
		cycle_entry = lowv ? ST_PRE : ST_FAST;
	endfunction : cycle_entry

	// Next-state decision
	always_comb begin
		nxt_state = state_ff;
		nxt_why = why_ff;
		start_cycle = 1'b0;
		if (disabled) begin
			nxt_state = ST_OFF;
		end else if (SENSE_MODE != mode_ff) begin
			// Any mode edge runs a detect, even mid-charge
			nxt_state = ST_DETECT;
			nxt_why = SENSE_MODE ? WHY_MODE_IN : WHY_MODE_OUT;
		end else begin
			unique case (state_ff)
				ST_OFF: begin
					if (ABOVE_RCH) begin
						nxt_state = ST_DETECT;
						nxt_why = WHY_PWRUP;
					end else begin
						nxt_state = cycle_entry(BAT_LOWV);
						start_cycle = 1'b1;
					end
				end
				ST_DETECT: begin
					if (DET_DONE && det_go) begin
						if (!DET_PRESENT) begin
							// In the mode the output still powers the system
							nxt_state = SENSE_MODE ? cycle_entry(BAT_LOWV) : ST_DETECT;
							nxt_why = SENSE_MODE ? why_ff : WHY_MISSING;
						end else if (why_ff == WHY_TERM) begin
							nxt_state = ST_DONE;
						end else if (why_ff == WHY_MODE_IN) begin
							nxt_state = cycle_entry(BAT_LOWV);
						end else begin
							nxt_state = cycle_entry(BAT_LOWV);
							start_cycle = 1'b1;
						end
					end
				end
				ST_PRE: begin
					if (!SENSE_MODE && tick && tmr_ff == 32'(PRE_TICKS - 1))
						nxt_state = ST_EXPIRED;
					else if (!BAT_LOWV)
						nxt_state = ST_FAST;
				end
				ST_FAST: begin
					if (!SENSE_MODE && tick && tmr_ff == 32'(FAST_TICKS - 1)) begin
						nxt_state = ST_EXPIRED;
					end else if (!SENSE_MODE && !fault && ABOVE_RCH && TAPER_TERM) begin
						nxt_state = ST_DETECT;
						nxt_why = WHY_TERM;
					end
				end
				ST_DONE: begin
					if (!ABOVE_RCH) begin
						nxt_state = cycle_entry(BAT_LOWV);
						start_cycle = 1'b1;
					end
				end
				ST_EXPIRED: begin
					nxt_state = ST_EXPIRED;
				end
				// Unused codes fall back to the off state
				default: begin
					nxt_state = ST_OFF;
				end
			endcase
		end
	end

	// State and reason registers
	always_ff @(posedge CLK) begin
		if (SRST) begin
			state_ff <= ST_OFF;
			why_ff <= WHY_PWRUP;
		end else begin
			state_ff <= nxt_state;
			why_ff <= nxt_why;
		end
	end

	// Safety timer: cleared on phase change, held clear in the mode
	always_ff @(posedge CLK) begin
		if (SRST || disabled || SENSE_MODE || mode_ff)
			tmr_ff <= '0;
		else if (nxt_state != state_ff)
			tmr_ff <= '0;
		else if ((state_ff == ST_PRE || state_ff == ST_FAST) && tick && !fault)
			tmr_ff <= tmr_ff + 32'h0000_0001;
	end

	// Boost window counts unslowed ticks from the start of every cycle
	always_ff @(posedge CLK) begin
		if (SRST || start_cycle)
			boost_ff <= '0;
		else if (pre_ff == 32'(TICK_CYCLES - 1) && boost_ff != 32'(BOOST_TICKS))
			boost_ff <= boost_ff + 32'h0000_0001;
	end

	// First-charge flag behind the status pin
	always_ff @(posedge CLK) begin
		if (SRST || state_ff == ST_OFF && !disabled) begin
			first_ff <= 1'b1;
		end else if (nxt_state == ST_PRE && state_ff != ST_PRE) begin
			first_ff <= 1'b1;
		end else if (start_cycle && state_ff == ST_DETECT) begin
			first_ff <= 1'b1;
		end else if (ABOVE_RCH && TAPER_TERM && state_ff == ST_FAST) begin
			first_ff <= 1'b0;
		end else if (nxt_state == ST_EXPIRED) begin
			first_ff <= 1'b0;
		end
	end

	// Battery presence from the last completed detect
	always_ff @(posedge CLK) begin
		if (SRST)
			absent_ff <= 1'b0;
		else if (state_ff == ST_DETECT && DET_DONE && det_go)
			absent_ff <= !DET_PRESENT;
	end

	// Outputs toward the power stage and the status pin, all registered except the constant STATUS_O
	always_ff @(posedge CLK) begin
		if (SRST) begin
			CHARGE_EN <= 1'b0;
			CUR_LIMIT_SEL <= ILIM_PROG;
			HALF_CURRENT <= 1'b0;
			VREG_REDUCED <= 1'b0;
			TERM_BOOST <= 1'b0;
			DET_RUN <= 1'b0;
			STATUS_OE_N <= 1'b1;
		end else begin
			CHARGE_EN <= !disabled && !fault
				&& (nxt_state == ST_PRE || nxt_state == ST_FAST);
			// Low pin caps everything, so it wins over high
			CUR_LIMIT_SEL <= ISEL_LOW ? ILIM_PROG : (ISEL_HIGH ? ILIM_500MA : ILIM_100MA);
			HALF_CURRENT <= TEMP_COOL && !fault;
			VREG_REDUCED <= TEMP_WARM && !fault;
			TERM_BOOST <= boost_ff != 32'(BOOST_TICKS);
			DET_RUN <= nxt_state == ST_DETECT && !disabled && !fault;
			STATUS_OE_N <= !(first_ff && !absent_ff && state_ff != ST_EXPIRED
				&& state_ff != ST_OFF);
		end
	end
	assign STATUS_O = 1'b0;

	// AXI4-Lite write path: address and data may come in either order
	logic aw_ff, w_ff; // Address or data captured
	logic [7:0] awaddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0] wstrb_ff;
	assign S_AXI_AWREADY = !aw_ff && !S_AXI_BVALID;
	assign S_AXI_WREADY = !w_ff && !S_AXI_BVALID;

	// Register offset decode shared by reads and writes
	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = a == CTRL_OFS || a == STATUS_OFS || a == TIMER_OFS;
	endfunction : is_mapped

	always_ff @(posedge CLK) begin
		if (SRST) begin
			aw_ff <= 1'b0;
			w_ff <= 1'b0;
			awaddr_ff <= 8'h00;
			wdata_ff <= 32'h0000_0000;
			wstrb_ff <= 4'h0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= RESP_OKAY;
		end else if (aw_ff && w_ff) begin
			// Both halves held: answer on the next edge
			aw_ff <= 1'b0;
			w_ff <= 1'b0;
			S_AXI_BVALID <= 1'b1;
			S_AXI_BRESP <= is_mapped(awaddr_ff) ? RESP_OKAY : RESP_DECERR;
		end else begin
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_ff <= 1'b1;
				awaddr_ff <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_ff <= 1'b1;
				wdata_ff <= S_AXI_WDATA;
				wstrb_ff <= S_AXI_WSTRB;
			end
			if (S_AXI_BVALID && S_AXI_BREADY)
				S_AXI_BVALID <= 1'b0;
		end
	end

	// Control register; only bit 0 is implemented
	always_ff @(posedge CLK) begin
		if (SRST)
			ctrl_ff <= CTRL_RST;
		else if (aw_ff && w_ff && awaddr_ff == CTRL_OFS && wstrb_ff[0])
			ctrl_ff <= {31'h0000_0000, wdata_ff[CTRL_DISABLE_BIT]};
	end

	// AXI4-Lite read path, data one cycle after the address is taken
	logic [31:0] status_word;
	assign S_AXI_ARREADY = !S_AXI_RVALID;
	always_comb begin
		status_word = 32'h0000_0000;
		status_word[ST_STATE_LSB +: 3] = state_ff;
		status_word[ST_MODE_BIT] = mode_ff;
		status_word[ST_FAULT_BIT] = fault;
		status_word[ST_ABSENT_BIT] = absent_ff;
		status_word[ST_FIRST_BIT] = first_ff;
		status_word[ST_BOOST_BIT] = TERM_BOOST;
		status_word[ST_SLOW_BIT] = slowed;
	end
	always_ff @(posedge CLK) begin
		if (SRST) begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h0000_0000;
			S_AXI_RRESP <= RESP_OKAY;
		end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			S_AXI_RVALID <= 1'b1;
			S_AXI_RRESP <= is_mapped(S_AXI_ARADDR) ? RESP_OKAY : RESP_DECERR;
			unique case (S_AXI_ARADDR)
				CTRL_OFS: S_AXI_RDATA <= ctrl_ff;
				STATUS_OFS: S_AXI_RDATA <= status_word;
				TIMER_OFS: S_AXI_RDATA <= tmr_ff;
				default: S_AXI_RDATA <= 32'h0000_0000;
			endcase
		end else if (S_AXI_RVALID && S_AXI_RREADY) begin
			S_AXI_RVALID <= 1'b0;
		end
	end

	// Checks on the sequencer
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SRST);
	a_ilim_low_caps: assert property (ISEL_LOW |=> CUR_LIMIT_SEL == ILIM_PROG)
		else $error("low select did not choose programmed limit");
	a_cool_halves: assert property (TEMP_COOL && !TEMP_COLD && !TEMP_HOT
		|=> HALF_CURRENT)
		else $error("cool zone did not halve current");
	a_warm_vreg_drop: assert property (TEMP_WARM && !TEMP_HOT && !TEMP_COLD
		|=> VREG_REDUCED)
		else $error("warm zone kept full voltage");
	a_fault_stops_charge: assert property (fault |=> !CHARGE_EN)
		else $error("charge enabled during temperature fault");
	a_sense_low_off: assert property (SENSE_LOW |=> state_ff == ST_OFF && !CHARGE_EN)
		else $error("sense pin low did not disable charge");
	a_mode_timer_held: assert property (mode_ff |-> tmr_ff == 32'h0000_0000)
		else $error("safety timer ran in no-timer mode");
	a_mode_edge_detect: assert property (!SRST && !disabled && SENSE_MODE != mode_ff
		|=> state_ff == ST_DETECT)
		else $error("mode edge did not start detect");
	a_expire_status_off: assert property ($rose(state_ff == ST_EXPIRED)
		|=> (STATUS_OE_N && !CHARGE_EN) [*2])
		else $error("expiry left charge or status on");
	a_absent_status_off: assert property (absent_ff |=> STATUS_OE_N)
		else $error("status on with battery missing");
	a_refresh_quiet: assert property (state_ff == ST_DONE && !ABOVE_RCH && !disabled
		&& SENSE_MODE == mode_ff |=> !first_ff ##1 STATUS_OE_N)
		else $error("refresh turned status on");
	a_fault_no_detect: assert property (fault |=> !DET_RUN)
		else $error("detect ran during temperature fault");
	c_full_cycle: cover property (state_ff == ST_FAST ##[1:1000] state_ff == ST_DONE);
	c_expiry: cover property (state_ff == ST_PRE ##1 state_ff == ST_EXPIRED);
	c_mode_round: cover property ($rose(mode_ff) ##[1:1000] $fell(mode_ff));
	c_refresh: cover property (state_ff == ST_DONE ##1 state_ff == ST_FAST);
endmodule : charge_control_sequencer

// file: core/charge_pkg.sv
package charge_pkg;
	// Register byte offsets on the AXI4-Lite slave
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] TIMER_OFS = 8'h08;
	// Control field positions and reset value
	localparam int CTRL_DISABLE_BIT = 0;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	// Status field positions
	localparam int ST_STATE_LSB = 0;
	localparam int ST_MODE_BIT = 4;
	localparam int ST_FAULT_BIT = 5;
	localparam int ST_ABSENT_BIT = 6;
	localparam int ST_FIRST_BIT = 7;
	localparam int ST_BOOST_BIT = 8;
	localparam int ST_SLOW_BIT = 9;
	// AXI response codes
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	// Input current limit selection codes
	localparam logic [1:0] ILIM_PROG = 2'h0;
	localparam logic [1:0] ILIM_100MA = 2'h1;
	localparam logic [1:0] ILIM_500MA = 2'h2;
	// Clock and time base
	localparam int CLK_HZ = 100_000_000;
	localparam int TICK_SEC = 1;
	localparam int TICK_CYCLES_DEF = CLK_HZ * TICK_SEC;
	// Safety and boost times, in their own units
	localparam int PRE_TIME_MIN = 30;
	localparam int FAST_TIME_H = 10;
	localparam int BOOST_TIME_MIN = 1;
	// Same times as counts of one-second ticks
	localparam int PRE_TICKS_DEF = PRE_TIME_MIN * 60 / TICK_SEC;
	localparam int FAST_TICKS_DEF = FAST_TIME_H * 3600 / TICK_SEC;
	localparam int BOOST_TICKS_DEF = BOOST_TIME_MIN * 60 / TICK_SEC;
	// Charge sequencer states
	typedef enum logic [2:0] {
		ST_OFF,
		ST_DETECT,
		ST_PRE,
		ST_FAST,
		ST_DONE,
		ST_EXPIRED
	} charge_state_t;
	// Why a battery detect is running
	typedef enum logic [2:0] {
		WHY_PWRUP,
		WHY_MODE_IN,
		WHY_MODE_OUT,
		WHY_TERM,
		WHY_MISSING
	} det_why_t;
endpackage : charge_pkg

// file: sim/battery_pack_model.sv
`timescale 1ns/1ps
// Battery pack seen through the detect probe; answers promptly and slowly by turns
module battery_pack_model (
	input wire logic clk, // System clock
	input wire logic srst, // Synchronous reset, active high
	input wire logic det_run, // Probe request from the sequencer
	input wire logic bat_in, // Bench says a cell is fitted
	output logic det_done, // One-cycle probe finished pulse
	output logic det_present // Probe result, meaningful with det_done only
);
	logic [2:0] wait_ff; // Cycles left before answering
	logic busy_ff; // Probe in progress
	logic slow_ff; // Alternates prompt and slow answers
	// Probe timing; the result line flips when idle so a stale value never looks valid
	always_ff @(posedge clk) begin
		if (srst) begin
			busy_ff <= 1'b0;
			wait_ff <= 3'h0;
			slow_ff <= 1'b0;
			det_done <= 1'b0;
			det_present <= 1'b0;
		end else if (det_done) begin
			det_done <= 1'b0;
			det_present <= ~det_present;
		end else if (!det_run) begin
			// Request withdrawn: drop the probe
			busy_ff <= 1'b0;
			det_present <= ~det_present;
		end else if (!busy_ff) begin
			busy_ff <= 1'b1;
			wait_ff <= slow_ff ? 3'h5 : 3'h1;
			slow_ff <= ~slow_ff;
		end else if (wait_ff == 3'h0) begin
			det_done <= 1'b1;
			det_present <= bat_in;
			busy_ff <= 1'b0;
		end else begin
			wait_ff <= wait_ff - 3'h1;
		end
	end
endmodule : battery_pack_model

// file: sim/charge_control_sequencer_tb_top.sv
`timescale 1ns/1ps
module charge_control_sequencer_tb_top;
	import charge_pkg::*;
	localparam int TCK = 4; // Short tick keeps safety timers to tens of cycles
	logic clk = 1'b0, srst = 1'b1; // Clock and reset
	logic [7:0] awaddr = 8'h00, araddr = 8'h00; // Bus addresses
	logic [31:0] wdata = 32'h0; // Write data
	logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b1, rready = 1'b1;
	logic isel_lo = 1'b0, isel_hi = 1'b0, sense_low = 1'b0, sense_mode = 1'b0, bat_in = 1'b1;
	logic t_cold = 1'b0, t_cool = 1'b0, t_warm = 1'b0, t_hot = 1'b0, en_off = 1'b0;
	logic pgood = 1'b1, lowv = 1'b1, above_rch = 1'b0, taper = 1'b0;
	logic treg = 1'b0, fold = 1'b0, usb = 1'b0; // Slowed-mode flags
	wire awready, wready, bvalid, arready, rvalid, det_done, det_present, det_run;
	wire charge_en, half_cur, vreg_red, boost, status_o, status_oe_n;
	wire [1:0] bresp, rresp, ilim;
	wire [31:0] rdata;
	wire status_pin = status_oe_n ? 1'b1 : status_o; // Host pull-up on the status pin
	int fail_count = 0, compares = 0, cyc = 0, i, t0;
	logic [31:0] seed = 32'd39; // Xorshift state
	logic [31:0] rd; // Last read data
	logic [1:0] rs; // Last response code

	charge_control_sequencer #(.TICK_CYCLES(TCK), .PRE_TICKS(5), .FAST_TICKS(8),
		.BOOST_TICKS(3)) u_charge_control_sequencer (.CLK(clk), .SRST(srst),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
		.ISEL_LOW(isel_lo), .ISEL_HIGH(isel_hi), .SENSE_LOW(sense_low), .SENSE_MODE(sense_mode),
		.TEMP_COLD(t_cold), .TEMP_COOL(t_cool), .TEMP_WARM(t_warm), .TEMP_HOT(t_hot),
		.BATT_ENABLE_OFF(en_off), .POWER_GOOD(pgood), .BAT_LOWV(lowv), .ABOVE_RCH(above_rch),
		.TAPER_TERM(taper), .THERMAL_REG(treg), .FOLDBACK(fold), .USB_LIMIT(usb),
		.DET_DONE(det_done), .DET_PRESENT(det_present), .DET_RUN(det_run),
		.CHARGE_EN(charge_en), .CUR_LIMIT_SEL(ilim), .HALF_CURRENT(half_cur),
		.VREG_REDUCED(vreg_red), .TERM_BOOST(boost), .STATUS_O(status_o),
		.STATUS_OE_N(status_oe_n));
	battery_pack_model u_battery_pack_model (.clk(clk), .srst(srst), .det_run(det_run),
		.bat_in(bat_in), .det_done(det_done), .det_present(det_present));

	// Free-running 100 MHz clock and a cycle count for timer windows
	initial begin
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
	end

	// Next pseudo-random word
	function automatic logic [31:0] xs(input logic [31:0] v);
		v = v ^ (v << 13);
		v = v ^ (v >> 17);
		v = v ^ (v << 5);
		return v;
	endfunction : xs
	// Expected limit code: a low pin caps everything
	function automatic logic [1:0] exp_ilim(input logic lo, input logic hi);
		return lo ? ILIM_PROG : (hi ? ILIM_500MA : ILIM_100MA);
	endfunction : exp_ilim

	task automatic report_and_stop;
		if (fail_count == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : report_and_stop
	task automatic cmp_bit(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp_bit
	task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp_word
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask : idle
	// Write one word; each half is released after the edge that takes it
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		r = 2'h0;
		for (int n = 0; n < 50; n++) begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) begin
				r = bresp;
				return;
			end
		end
		fail_count++;
		report_and_stop();
	endtask : axi_wr
	// Read one word; rready stays high, the address is released after the edge that takes it
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		d = 32'h0;
		r = 2'h0;
		for (int n = 0; n < 50; n++) begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) begin
				d = rdata;
				r = rresp;
				return;
			end
		end
		fail_count++;
		report_and_stop();
	endtask : axi_rd
	// Poll the state field a bounded number of times
	task automatic wait_state(input logic [2:0] s, input int tries);
		for (int n = 0; n < tries; n++) begin
			axi_rd(STATUS_OFS, rd, rs);
			if (rd[2:0] === s) break;
		end
		cmp_word({29'h0, rd[2:0]}, {29'h0, s});
	endtask : wait_state
	// Soft disable then enable through the control register
	task automatic restart;
		axi_wr(CTRL_OFS, 32'h1, rs);
		idle(2);
		cmp_bit(charge_en, 1'b0);
		axi_rd(TIMER_OFS, rd, rs);
		cmp_word(rd, 32'h0);
		axi_wr(CTRL_OFS, 32'h0, rs);
		wait_state(ST_FAST, 10);
	endtask : restart

	// Timeout guard
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		report_and_stop();
	end

	initial begin
		idle(10);
		srst <= 1'b0;
		// Deep battery at power-up: pre-charge, status pulling, then timer expiry
		wait_state(ST_PRE, 10);
		t0 = cyc;
		cmp_bit(status_pin, 1'b0);
		wait_state(ST_EXPIRED, 20);
		cmp_bit((cyc - t0 >= 14) && (cyc - t0 <= 26), 1'b1);
		idle(3);
		cmp_bit(status_pin, 1'b1);
		cmp_bit(charge_en, 1'b0);
		// Host pulls the sense pin low, releases it, and a fresh first charge starts
		sense_low <= 1'b1;
		lowv <= 1'b0;
		idle(3);
		cmp_bit(charge_en, 1'b0);
		axi_rd(TIMER_OFS, rd, rs);
		cmp_word(rd, 32'h0);
		sense_low <= 1'b0;
		wait_state(ST_FAST, 10);
		cmp_bit(status_pin, 1'b0);
		cmp_bit(boost, 1'b1);
		idle(20);
		cmp_bit(boost, 1'b0);
		// One slowed mode picked at random halves the fast timer rate
		seed = xs(seed);
		treg <= (seed[1:0] == 2'h0);
		fold <= (seed[1:0] == 2'h1);
		usb <= seed[1];
		restart();
		t0 = cyc;
		idle(40);
		axi_rd(STATUS_OFS, rd, rs);
		cmp_word({29'h0, rd[2:0]}, {29'h0, ST_FAST});
		cmp_bit(rd[ST_SLOW_BIT], 1'b1);
		wait_state(ST_EXPIRED, 20);
		cmp_bit(cyc - t0 >= 50, 1'b1);
		treg <= 1'b0;
		fold <= 1'b0;
		usb <= 1'b0;
		// Temperature zones: cold, cool, normal, warm, hot
		restart();
		for (i = 0; i < 5; i++) begin
			t_cold <= (i == 0);
			t_cool <= (i == 1);
			t_warm <= (i == 3);
			t_hot <= (i == 4);
			idle(3);
			cmp_bit(half_cur, i == 1);
			cmp_bit(vreg_red, i == 3);
			cmp_bit(charge_en, i != 0 && i != 4);
		end
		t_hot <= 1'b0;
		// Taper at regulation terminates, then a sag refreshes with status off
		restart();
		above_rch <= 1'b1;
		taper <= 1'b1;
		wait_state(ST_DONE, 10);
		idle(2);
		cmp_bit(status_pin, 1'b1);
		cmp_bit(charge_en, 1'b0);
		above_rch <= 1'b0;
		taper <= 1'b0;
		wait_state(ST_FAST, 10);
		cmp_bit(status_pin, 1'b1);
		// Cell pulled while the sense pin stays active: detection keeps running
		bat_in <= 1'b0;
		above_rch <= 1'b1;
		taper <= 1'b1;
		idle(30);
		axi_rd(STATUS_OFS, rd, rs);
		cmp_word({29'h0, rd[2:0]}, {29'h0, ST_DETECT});
		cmp_bit(rd[ST_ABSENT_BIT], 1'b1);
		cmp_bit(status_pin, 1'b1);
		bat_in <= 1'b1;
		above_rch <= 1'b0;
		taper <= 1'b0;
		// Mode entry: timer held, no termination, then exit restarts the cycle
		restart();
		sense_mode <= 1'b1;
		idle(10);
		axi_rd(STATUS_OFS, rd, rs);
		cmp_bit(rd[ST_MODE_BIT], 1'b1);
		idle(40);
		axi_rd(TIMER_OFS, rd, rs);
		cmp_word(rd, 32'h0);
		above_rch <= 1'b1;
		taper <= 1'b1;
		wait_state(ST_FAST, 3);
		idle(3);
		cmp_bit(status_pin, 1'b1);
		above_rch <= 1'b0;
		taper <= 1'b0;
		sense_mode <= 1'b0;
		idle(12);
		wait_state(ST_FAST, 10);
		cmp_bit(status_pin, 1'b0);
		// Every select combination first, then random ones
		for (i = 0; i < 8; i++) begin
			seed = xs(seed);
			isel_lo <= (i < 4) ? i[0] : seed[0];
			isel_hi <= (i < 4) ? i[1] : seed[1];
			idle(3);
			cmp_word({30'h0, ilim}, {30'h0, exp_ilim(isel_lo, isel_hi)});
		end
		// Unmapped word: decode error both ways
		seed = xs(seed);
		axi_rd({seed[7:2] | 6'h03, 2'b00}, rd, rs);
		cmp_word({rd[29:0], rs}, {30'h0, RESP_DECERR});
		axi_wr({seed[7:2] | 6'h03, 2'b00}, seed, rs);
		cmp_word({30'h0, rs}, {30'h0, RESP_DECERR});
		// Mid-run reset with a full output: power-up detect, then a first charge
		srst <= 1'b1;
		above_rch <= 1'b1;
		idle(2);
		srst <= 1'b0;
		idle(2);
		cmp_bit(det_run, 1'b1);
		wait_state(ST_FAST, 10);
		cmp_bit(status_pin, 1'b0);
		report_and_stop();
	end
endmodule : charge_control_sequencer_tb_top
